// File: hdl/quadrature_position_input.sv
`timescale 1ns/1ns
// Overview of operation
// R01: pulse multiplication selectable as x1, x2 or x4 on counting channels.
// R02: encoder keeps counting edges at least 150 ns apart, max 1 MHz.
// R03: direction reversal counts correctly even with zero edge spacing.
// R04: encoder keeps reference transitions 100 ns clear of counting edges.
// R05: any channel unchanged for 1.2 us or longer raises a fault.
// R06: low level on the fault input means measuring-system error.
// R07: tri-stated encoder output stages are reported as an error.
// R08: open fault input reads high, meaning no error.
// R09: counting direction reversible by a configuration input, no rewiring.
// R10: encoder channels must never be swapped to reverse direction.
// R11: direction follows which quadrature channel leads in phase.
// R12: inputs synchronised before edge detection; count latched on reference.
module quadrature_position_input
    import quad_pkg::*;
#(
    parameter int POS_WIDTH  = 32,
    parameter int STUCK_CNT  = STUCK_CYCLES
) (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    // encoder lines
    input  wire enc_lines_t           enc_in,
    input  wire enc_open_t            enc_open,
    input  wire logic                 fault_in_n,
    // configuration
    input  wire logic [1:0]           mult_sel,
    input  wire logic                 dir_invert,
    // results
    output logic [POS_WIDTH-1:0]      position,
    output logic [POS_WIDTH-1:0]      ref_position,
    output logic                      ref_seen,
    output logic                      count_pulse,
    output logic                      count_up,
    output fault_t                    fault
);
    localparam int SW = 7;
    localparam int CW = $clog2(STUCK_CNT + 1);

    // refuse widths and windows the logic cannot serve, at elaboration
    if (POS_WIDTH < 2 || POS_WIDTH > 64) begin : g_bad_pos_width
        $error("quadrature_position_input: bad POS_WIDTH");
    end
    if (STUCK_CNT < 2) begin : g_bad_stuck_cnt
        $error("quadrature_position_input: STUCK_CNT too small");
    end

    // synchronised copies of every encoder input; the fault line goes
    // through inverted so the cleared synchroniser reads as healthy and
    // no false fault follows reset
    logic [SW-1:0] sync_v;
    quad_sync #(.WIDTH(SW)) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({enc_in.a, enc_in.b, enc_in.z, enc_open.a_open,
                    enc_open.b_open, enc_open.z_open, ~fault_in_n}),
        .sync_out (sync_v)
    ); // see R12

    logic a_s;
    logic b_s;
    logic z_s;
    logic open_any;
    logic fault_n_s;
    assign a_s       = sync_v[6];
    assign b_s       = sync_v[5];
    assign z_s       = sync_v[4];
    assign open_any  = |sync_v[3:1];
    assign fault_n_s = ~sync_v[0];

    // decode one transition of the 2-bit gray state: +1, -1 or none
    function automatic logic [1:0] step_of(input logic [1:0] prv,
                                           input logic [1:0] cur);
        logic [1:0] fwd;
        fwd = {prv[0], ~prv[1]};
        if (cur == prv)
            step_of = 2'b00;
        else if (cur == fwd)
            step_of = 2'b01;
        else if (prv == {cur[0], ~cur[1]})
            step_of = 2'b11;
        else
            step_of = 2'b00; // both lines moved: illegal, ignored
    endfunction

    // previous sampled state
    logic [1:0]           ab_q;
    logic [1:0]           ab_d;
    logic                 z_q;
    logic                 z_d;
    logic [POS_WIDTH-1:0] pos_q;
    logic [POS_WIDTH-1:0] pos_d;
    logic [POS_WIDTH-1:0] ref_q;
    logic [POS_WIDTH-1:0] ref_d;
    logic                 seen_q;
    logic                 seen_d;
    logic                 pulse_q;
    logic                 pulse_d;
    logic                 up_q;
    logic                 up_d;
    logic [1:0]           step;
    logic                 take;
    logic                 up_raw;

    // counting: every edge decoded, multiplication selects which count
    always_comb begin
        ab_d   = {a_s, b_s};
        z_d    = z_s;
        step   = step_of(ab_q, {a_s, b_s}); // see R11
        up_raw = (step == 2'b01) ^ dir_invert; // see R09
        // x4 counts all edges, x2 only edges of a, x1 only rising a going forward and falling a going back
        unique case (mult_sel)
            MULT_X2: take = step[0] && (a_s != ab_q[1]);
            MULT_X1: take = step[0] && (a_s != ab_q[1]) &&
                            (up_raw ^ dir_invert ? a_s : ~a_s);
            default: take = step[0];
        endcase // see R01
        pos_d   = pos_q;
        pulse_d = take;
        up_d    = take ? up_raw : up_q;
        // each edge judged on its own, so a reversal right after
        // the previous edge still counts the right way
        if (take)
            pos_d = up_raw ? pos_q + 1'b1 : pos_q - 1'b1; // see R03
        ref_d  = ref_q;
        seen_d = seen_q;
        if (z_s && !z_q) begin
            ref_d  = pos_d;
            seen_d = 1'b1;
        end // see R12
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ab_q    <= 2'h0;
            z_q     <= 1'b0;
            pos_q   <= POS_RESET[POS_WIDTH-1:0];
            ref_q   <= POS_RESET[POS_WIDTH-1:0];
            seen_q  <= 1'b0;
            pulse_q <= 1'b0;
            up_q    <= 1'b0;
        end else begin
            ab_q    <= ab_d;
            z_q     <= z_d;
            pos_q   <= pos_d;
            ref_q   <= ref_d;
            seen_q  <= seen_d;
            pulse_q <= pulse_d;
            up_q    <= up_d;
        end
    end

    // phase watchdog: each line must toggle within the stuck window
    logic [CW-1:0] cnt_a_q;
    logic [CW-1:0] cnt_a_d;
    logic [CW-1:0] cnt_b_q;
    logic [CW-1:0] cnt_b_d;
    logic [CW-1:0] cnt_z_q;
    logic [CW-1:0] cnt_z_d;
    fault_t        fault_q;
    fault_t        fault_d;

    function automatic logic [CW-1:0] watch(input logic [CW-1:0] c,
                                            input logic moved);
        if (moved)
            watch = '0;
        else if (c < CW'(STUCK_CNT))
            watch = c + 1'b1;
        else
            watch = c;
    endfunction

    // a standing encoder trips this too; the limitation is documented
    always_comb begin
        cnt_a_d = watch(cnt_a_q, a_s != ab_q[1]);
        cnt_b_d = watch(cnt_b_q, b_s != ab_q[0]);
        cnt_z_d = watch(cnt_z_q, z_s != z_q);
        fault_d.stuck = (cnt_a_d >= CW'(STUCK_CNT)) ||
                        (cnt_b_d >= CW'(STUCK_CNT)) ||
                        (cnt_z_d >= CW'(STUCK_CNT)); // see R05
        fault_d.open_line = open_any; // see R07
        // an open pin is pulled high outside, high means healthy
        fault_d.ext_fault = ~fault_n_s; // see R06 see R08
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_a_q <= '0;
            cnt_b_q <= '0;
            cnt_z_q <= '0;
            fault_q <= '0;
        end else begin
            cnt_a_q <= cnt_a_d;
            cnt_b_q <= cnt_b_d;
            cnt_z_q <= cnt_z_d;
            fault_q <= fault_d;
        end
    end

    assign position     = pos_q;
    assign ref_position = ref_q;
    assign ref_seen     = seen_q;
    assign count_pulse  = pulse_q;
    assign count_up     = up_q;
    assign fault        = fault_q;

    // assertions
    property p_ext_fault;
        @(posedge clock) disable iff (sys_rst)
        !fault_n_s |=> fault.ext_fault;
    endproperty
    a_ext_fault: assert property (p_ext_fault) // see R06
        else $error("fault input low not reported");

    property p_no_ext_fault;
        @(posedge clock) disable iff (sys_rst)
        fault_n_s |=> !fault.ext_fault;
    endproperty
    a_no_ext_fault: assert property (p_no_ext_fault) // see R08
        else $error("fault input high reported as error");

    property p_open;
        @(posedge clock) disable iff (sys_rst)
        open_any |=> fault.open_line;
    endproperty
    a_open: assert property (p_open) // see R07
        else $error("open line not reported");

    property p_stuck;
        @(posedge clock) disable iff (sys_rst)
        (cnt_a_q == CW'(STUCK_CNT - 1)) && (a_s == ab_q[1])
            |=> fault.stuck;
    endproperty
    a_stuck: assert property (p_stuck) // see R05
        else $error("stuck channel not reported");

    property p_count_step;
        @(posedge clock) disable iff (sys_rst)
        take |=> count_pulse && (position != $past(position));
    endproperty
    a_count_step: assert property (p_count_step) // see R01
        else $error("counted edge did not move position");

    property p_dir;
        @(posedge clock) disable iff (sys_rst)
        take |=> count_up == (($past(step) == 2'b01) ^ $past(dir_invert));
    endproperty
    a_dir: assert property (p_dir) // see R09
        else $error("count direction wrong");

    sequence s_fwd;
        step == 2'b01 && take;
    endsequence
    sequence s_back;
        step == 2'b11 && take;
    endsequence
    property p_reverse;
        @(posedge clock) disable iff (sys_rst)
        s_fwd ##1 s_back |=> position == $past(position, 2);
    endproperty
    a_reverse: assert property (p_reverse) // see R03
        else $error("reversal miscounted");

    property p_x4_all;
        @(posedge clock) disable iff (sys_rst)
        (mult_sel == MULT_X4) && step[0] |-> take;
    endproperty
    a_x4_all: assert property (p_x4_all) // see R01
        else $error("x4 edge dropped");

    property p_ref;
        @(posedge clock) disable iff (sys_rst)
        z_s && !z_q |=> ref_seen && ref_position == position;
    endproperty
    a_ref: assert property (p_ref) // see R12
        else $error("reference latch wrong");
endmodule

// File: hdl/quad_pkg.sv
package quad_pkg;

    // pulse multiplication codes
    localparam logic [1:0] MULT_X1 = 2'h0;
    localparam logic [1:0] MULT_X2 = 2'h1;
    localparam logic [1:0] MULT_X4 = 2'h2;

    // timing
    localparam int CLK_PERIOD_NS   = 10;
    localparam int STUCK_TIME_NS   = 1200;
    localparam int STUCK_CYCLES    = STUCK_TIME_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES     = 2;

    // reset values
    localparam logic [31:0] POS_RESET = 32'h0000_0000;

    // raw encoder lines, differential receiver outputs
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } enc_lines_t;

    // per-line open (tri-state) indication from receivers
    typedef struct packed {
        logic a_open;
        logic b_open;
        logic z_open;
    } enc_open_t;

    // fault summary
    typedef struct packed {
        logic stuck;
        logic open_line;
        logic ext_fault;
    } fault_t;

endpackage

// File: hdl/quad_sync.sv
`timescale 1ns/1ns
// two flip-flop synchroniser for a bundle of levels
module quad_sync
    import quad_pkg::*;
#(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // refuse a bundle the logic cannot hold, at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("quad_sync: WIDTH must be at least 1");
    end

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;
endmodule

// File: sim/enc_model.sv
`timescale 1ns/1ns
// behavioural encoder: quadrature pair, reference and fault line
module enc_model
    import quad_pkg::*;
(
    // clock
    input  wire logic clock,
    // lines toward the block
    output enc_lines_t enc_in,
    output enc_open_t  enc_open,
    output logic       fault_in_n
);
    logic fault_drv;
    logic fault_lvl;

    // a released fault output is pulled up, so it reads as no error
    assign fault_in_n = fault_drv ? fault_lvl : 1'b1;

    // idle lines at time zero
    initial begin
        enc_in = '0;
        enc_open = '0;
        fault_drv = 1'b0;
        fault_lvl = 1'b1;
    end

    // one step, b leads a going forward; the pair is never swapped
    task automatic step(input logic fwd, input int gap);
        @(negedge clock);
        if (fwd != (enc_in.a == enc_in.b)) begin
            enc_in.a = ~enc_in.a;
        end else begin
            enc_in.b = ~enc_in.b;
        end
        repeat (gap) @(negedge clock);
    endtask

    // reference pulse kept 10 cycles clear of counting edges
    task automatic ref_pulse;
        @(negedge clock);
        enc_in.z = 1'b1;
        repeat (10) @(negedge clock);
        enc_in.z = 1'b0;
        repeat (10) @(negedge clock);
    endtask

    // floating outputs settle away from their last level, all at once
    task automatic release_lines(input logic off);
        @(negedge clock);
        enc_open = {3{off}};
        enc_in = ~enc_in;
        repeat (16) @(negedge clock);
    endtask

    // drive or release the fault output
    task automatic set_fault(input logic drv, input logic lvl);
        @(negedge clock);
        fault_drv = drv;
        fault_lvl = lvl;
        repeat (6) @(negedge clock);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import quad_pkg::*;
    localparam int STUCK_SIM = 60;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [1:0]  mult_sel = MULT_X4;
    logic        dir_invert = 1'b0;
    enc_lines_t  enc_in;
    enc_open_t   enc_open;
    logic        fault_in_n;
    logic [31:0] position;
    logic [31:0] ref_position;
    logic        ref_seen;
    logic        count_pulse;
    logic        count_up;
    fault_t      fault;
    logic [31:0] exp_pos = 32'h0000_0000;
    int          err_count = 0;
    int          n_compared = 0;

    // 100 MHz clock
    always #5 clock = ~clock;

    enc_model i_enc_model (
        .clock(clock), .enc_in(enc_in), .enc_open(enc_open),
        .fault_in_n(fault_in_n));

    quadrature_position_input #(.STUCK_CNT(STUCK_SIM))
        i_quadrature_position_input (
        .clock(clock), .sys_rst(sys_rst), .enc_in(enc_in),
        .enc_open(enc_open), .fault_in_n(fault_in_n),
        .mult_sel(mult_sel), .dir_invert(dir_invert),
        .position(position), .ref_position(ref_position),
        .ref_seen(ref_seen), .count_pulse(count_pulse),
        .count_up(count_up), .fault(fault));

    task automatic cmp_vec(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp,
                           input logic got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic print_verdict;
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // step at x4 with no inversion, one count per edge
    task automatic mv(input logic fwd, input int gap);
        i_enc_model.step(fwd, gap);
        exp_pos = fwd ? exp_pos + 32'h0000_0001 : exp_pos - 32'h0000_0001;
    endtask

    task automatic t_reset;
        cmp_vec("position", exp_pos, position);
        cmp_bit("ref_seen", 1'b0, ref_seen);
        cmp_vec("fault", 32'h0000_0000, {29'h0, fault});
    endtask

    // full cycles forward then back, every factor, both senses
    task automatic t_mult;
        logic [1:0] sel [4] = '{MULT_X1, MULT_X2, MULT_X4, 2'h3};
        logic [31:0] n [4] = '{32'h1, 32'h2, 32'h4, 32'h4};
        for (int i = 0; i < 4; i++) begin
            for (int d = 0; d < 2; d++) begin
                mult_sel = sel[i];
                dir_invert = d[0];
                repeat (4) i_enc_model.step(1'b1, 16);
                exp_pos = d ? exp_pos - n[i] : exp_pos + n[i];
                cmp_vec("position fwd", exp_pos, position);
                repeat (4) i_enc_model.step(1'b0, 16);
                exp_pos = d ? exp_pos + n[i] : exp_pos - n[i];
                cmp_vec("position back", exp_pos, position);
            end
        end
        mult_sel = MULT_X4;
        dir_invert = 1'b0;
    endtask

    // one-cycle pulse and direction flag for each sense
    task automatic t_pulse;
        int k;
        for (int d = 1; d >= 0; d--) begin
            mv(d[0], 0);
            k = 0;
            while (count_pulse !== 1'b1 && k < 8) begin
                @(negedge clock);
                k++;
            end
            if (k == 8) begin
                cmp_bit("count_pulse", 1'b1, count_pulse);
                return;
            end
            cmp_bit("count_up", d[0], count_up);
            @(negedge clock);
            cmp_bit("count_pulse low", 1'b0, count_pulse);
            repeat (12) @(negedge clock);
        end
    endtask

    // reversal one cycle after the previous edge, zero spacing
    task automatic t_reverse;
        mv(1'b1, 0);
        mv(1'b0, 16);
        cmp_vec("position", exp_pos, position);
    endtask

    task automatic t_ref;
        mv(1'b1, 16);
        i_enc_model.ref_pulse;
        cmp_bit("ref_seen", 1'b1, ref_seen);
        cmp_vec("ref_position", exp_pos, ref_position);
    endtask

    task automatic t_fault;
        i_enc_model.set_fault(1'b1, 1'b0);
        cmp_bit("ext_fault", 1'b1, fault.ext_fault);
        i_enc_model.set_fault(1'b0, 1'b0);
        cmp_bit("ext_fault", 1'b0, fault.ext_fault);
    endtask

    // a and b flip together while open: no count may result
    task automatic t_open;
        i_enc_model.release_lines(1'b1);
        cmp_bit("open_line", 1'b1, fault.open_line);
        cmp_vec("position", exp_pos, position);
        i_enc_model.release_lines(1'b0);
        cmp_bit("open_line", 1'b0, fault.open_line);
        cmp_vec("position", exp_pos, position);
    endtask

    // standstill past the limit, then every line moves at least once
    task automatic t_stuck;
        repeat (70) @(negedge clock);
        cmp_bit("stuck", 1'b1, fault.stuck);
        mv(1'b1, 16);
        i_enc_model.ref_pulse;
        mv(1'b1, 5);
        cmp_bit("stuck", 1'b0, fault.stuck);
        cmp_vec("position", exp_pos, position);
    endtask

    // reset for 12 cycles, then the scenarios in turn
    initial begin
        repeat (12) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        t_reset;
        t_mult;
        t_pulse;
        t_reverse;
        t_ref;
        t_fault;
        t_open;
        t_stuck;
        print_verdict;
    end
endmodule
